// ### pkg/pursq_pkg.sv
// Constants shared by the power-up and reset sequencer.
// Assumes a 100 MHz REF_CLK and a classic Wishbone register port.
package pursq_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ         = 100_000_000;
  localparam int unsigned REF_IN_HZ          = 1_000_000;
  localparam int unsigned REF_PERIOD_CYC     = SYS_CLK_HZ / REF_IN_HZ;
  localparam int unsigned REF_TOL_CYC        = 2;
  localparam int unsigned REF_STABLE_PERIODS = 8;
  // Supply must stay good this long before release, least time, rounded up
  localparam int unsigned SUPPLY_FILT_NS     = 361;
  localparam int unsigned SUPPLY_FILT_CYC    = (SUPPLY_FILT_NS * (SYS_CLK_HZ / 1_000_000)
                                                + 999) / 1000;
  localparam int unsigned IO_READY_NS        = 10_000;
  localparam int unsigned IO_READY_CYC       = (IO_READY_NS * (SYS_CLK_HZ / 1_000_000)
                                                + 999) / 1000;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [11:0] PATTERN_ADDR = 12'h008;
  localparam logic [11:0] MC_EN1_ADDR  = 12'h100;
  localparam logic [11:0] MC_EN2_ADDR  = 12'h120;
  // CTRL fields
  localparam int unsigned CTRL_GATE_EN_BIT  = 0;
  localparam int unsigned CTRL_SOFT_RST_BIT = 1;
  // MC_EN fields
  localparam int unsigned MC_EN_BIT         = 0;
  // STATUS fields
  localparam int unsigned ST_SUPPLY_GOOD    = 0;
  localparam int unsigned ST_CHARGE_PUMP    = 1;
  localparam int unsigned ST_PLL_EN         = 2;
  localparam int unsigned ST_PLL_LOCKED     = 3;
  localparam int unsigned ST_IO_READY       = 4;
  localparam int unsigned ST_GATE_REG       = 5;
  localparam int unsigned ST_MC_EN1         = 6;
  localparam int unsigned ST_MC_EN2         = 7;
  localparam int unsigned ST_BOOST          = 8;
  localparam int unsigned ST_PHASE_LSB      = 12;
  // Values
  localparam logic [31:0] CONTROL_PATTERN   = 32'h0000_00A8;
  localparam logic [31:0] RESET_READ_VALUE  = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_VALUE    = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Power-up phases shown in STATUS
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_SUPPLY,
    PH_CHARGE_PUMP,
    PH_PLL,
    PH_HOST_RESET,
    PH_IO_READY,
    PH_CONFIG,
    PH_RUN
  } pursq_phase_t;
endpackage

// ### hw/pursq_hold_timer.sv
// Qualifies a level: done rises once the level has been high for a count.
// Assumes a synchronous level input on the system clock.
`timescale 1ns/1ps
module pursq_hold_timer #(
  parameter int unsigned COUNT = 4
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic level,
  output logic      done
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  initial begin
    if (COUNT < 1) begin
      $error("pursq_hold_timer: COUNT must be at least 1");
    end
  end

  localparam int unsigned CW = $clog2(COUNT + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } pursq_ht_state_t;

  pursq_ht_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    // Any drop restarts the wait, so a glitching level never qualifies
    if (!level) begin
      s_d.cnt  = '0;
      s_d.done = 1'b0;
    end else if (s_q.cnt != CW'(COUNT)) begin
      s_d.cnt  = s_q.cnt + CW'(1);
      s_d.done = (s_q.cnt + CW'(1)) == CW'(COUNT);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule

// ### hw/pursq_ref_monitor.sv
// Watches the sampled 1 MHz reference and reports it stable.
// Assumes ref_in is synchronous to the 100 MHz system clock.
`timescale 1ns/1ps
module pursq_ref_monitor #(
  parameter int unsigned PERIOD_CYC = 100,
  parameter int unsigned TOL_CYC    = 2,
  parameter int unsigned STABLE_N   = 8
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ref_in,
  output logic      stable
);
  initial begin
    if (TOL_CYC >= PERIOD_CYC / 2 || STABLE_N < 1) begin
      $error("pursq_ref_monitor: bad tolerance or stable count");
    end
  end

  localparam int unsigned PW = $clog2(2 * PERIOD_CYC + 1);
  localparam int unsigned SW = $clog2(STABLE_N + 1);

  typedef struct packed {
    logic          prev;
    logic [PW-1:0] per;
    logic [SW-1:0] good;
  } pursq_rm_state_t;

  pursq_rm_state_t s_q, s_d;
  logic            rise;
  logic            in_win;

  always_comb begin
    s_d    = s_q;
    rise   = ref_in & ~s_q.prev;
    in_win = (s_q.per >= PW'(PERIOD_CYC - TOL_CYC)) &&
             (s_q.per <= PW'(PERIOD_CYC + TOL_CYC));
    s_d.prev = ref_in;
    if (rise) begin
      s_d.per = PW'(1);
      if (!in_win) begin
        s_d.good = '0;
      end else if (s_q.good != SW'(STABLE_N)) begin
        s_d.good = s_q.good + SW'(1);
      end
    end else if (s_q.per == PW'(2 * PERIOD_CYC)) begin
      // Lost clock: no edge for two periods drops the stable flag
      s_d.good = '0;
    end else begin
      s_d.per = s_q.per + PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stable = (s_q.good == SW'(STABLE_N));
endmodule

// ### hw/pursq_sequencer.sv
// Power-up and reset sequencer of a solenoid gate-driver controller.
// Assumes synchronous inputs on REF_CLK and a classic Wishbone master.
//
// Overview of operation
// - Supply-good reset stays asserted until core logic supply is in range.
// - Charge pump starts after supply-good release and boost rail is adequate.
// - PLL starts only once a stable 1.0 MHz reference is seen.
// - Serial access needs supply-good release, io-ready delay and reset pin high.
// - Gate-supply regulator is off after reset; software enables it by write.
// - Gate-supply regulator starts only when the charge pump is operational.
// - Boost converter control starts only after a microcore is enabled.
// - After microcore enable, trigger input levels drive load actuation.
// - Core reset is AND of supply-good, reset pin and serial soft reset.
// - During core reset the serial port is inactive; no control pattern.
// - Microcores are enabled through per-channel enable registers.
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module pursq_sequencer #(
  parameter int unsigned NTRIG        = 4,
  parameter int unsigned IO_READY_CYC = pursq_pkg::IO_READY_CYC
) (
  input  wire logic              REF_CLK,
  input  wire logic              SRST,
  // Wishbone slave
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [11:0]       WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  // Supply and analog status
  input  wire logic              CORE_LOGIC_SUPPLY_OK,
  input  wire logic              BOOST_RAIL_OK,
  input  wire logic              CHARGE_PUMP_OK,
  input  wire logic              REF_CLK_IN,
  input  wire logic              PLL_LOCKED,
  input  wire logic              HOST_RESET_PIN_N,
  input  wire logic [NTRIG-1:0]  ACTUATION_TRIGGER_INPUTS,
  // Sequencing outputs
  output logic                   SUPPLY_GOOD_RESET,
  output logic                   CORE_RESET_COMBINED_N,
  output logic                   CHARGE_PUMP_EN,
  output logic                   PLL_EN,
  output logic                   SERIAL_READY,
  output logic                   GATE_SUPPLY_REGULATOR_EN,
  output logic [1:0]             MICROCORE_EN,
  output logic                   BOOST_EN,
  output logic [NTRIG-1:0]       ACTUATE
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  initial begin
    if (NTRIG < 1 || NTRIG > 8 || IO_READY_CYC < 1) begin
      $error("pursq_sequencer: NTRIG must be 1..8 and IO_READY_CYC at least 1");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   sgr_n;
    logic                   cp_en;
    logic                   pll_en;
    logic                   soft_rst_n;
    logic                   gate_cfg;
    logic                   gate_en;
    logic [1:0]             mc_en;
    logic                   boost_en;
    logic [NTRIG-1:0]       act;
    logic                   ack;
    logic [31:0]            rdata;
    pursq_pkg::pursq_phase_t phase;
  } pursq_seq_state_t;

  pursq_seq_state_t s_q, s_d;

  logic        supply_done;
  logic        ref_stable;
  logic        io_ready;
  logic        core_rst_n;
  logic        serial_on;
  logic        req;
  logic        wr_now;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // Qualifiers
  // ----------------------------------------------------------------
  pursq_hold_timer #(
    .COUNT (pursq_pkg::SUPPLY_FILT_CYC)
  ) u_supply_filt (
    .clk   (REF_CLK),
    .srst  (SRST),
    .level (CORE_LOGIC_SUPPLY_OK),
    .done  (supply_done)
  );

  // Delay counts from the supply-good release only
  pursq_hold_timer #(
    .COUNT (IO_READY_CYC)
  ) u_io_ready (
    .clk   (REF_CLK),
    .srst  (SRST),
    .level (s_q.sgr_n),
    .done  (io_ready)
  );

  pursq_ref_monitor #(
    .PERIOD_CYC (pursq_pkg::REF_PERIOD_CYC),
    .TOL_CYC    (pursq_pkg::REF_TOL_CYC),
    .STABLE_N   (pursq_pkg::REF_STABLE_PERIODS)
  ) u_ref_mon (
    .clk    (REF_CLK),
    .srst   (SRST),
    .ref_in (REF_CLK_IN),
    .stable (ref_stable)
  );

  // ----------------------------------------------------------------
  // Reset combination and serial gate
  // ----------------------------------------------------------------
  assign core_rst_n = s_q.sgr_n & HOST_RESET_PIN_N & s_q.soft_rst_n;
  // Reset pin low also closes the port, since it takes part in core reset
  assign serial_on  = core_rst_n & io_ready;
  assign req        = WB_CYC_I & WB_STB_I;
  assign wr_now     = req & WB_WE_I & s_q.ack & serial_on & WB_SEL_I[0];

  always_comb begin
    status                                = '0;
    status[pursq_pkg::ST_SUPPLY_GOOD]     = s_q.sgr_n;
    status[pursq_pkg::ST_CHARGE_PUMP]     = CHARGE_PUMP_OK;
    status[pursq_pkg::ST_PLL_EN]          = s_q.pll_en;
    status[pursq_pkg::ST_PLL_LOCKED]      = PLL_LOCKED;
    status[pursq_pkg::ST_IO_READY]        = io_ready;
    status[pursq_pkg::ST_GATE_REG]        = s_q.gate_en;
    status[pursq_pkg::ST_MC_EN1]          = s_q.mc_en[0];
    status[pursq_pkg::ST_MC_EN2]          = s_q.mc_en[1];
    status[pursq_pkg::ST_BOOST]           = s_q.boost_en;
    status[pursq_pkg::ST_PHASE_LSB +: 4]  = s_q.phase;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Supply-good reset: released only after the supply has held in range
    s_d.sgr_n = supply_done;
    s_d.cp_en = s_q.sgr_n & BOOST_RAIL_OK;
    // Lost reference stops the PLL again; it restarts once the reference is stable again
    s_d.pll_en = s_q.sgr_n & ref_stable;
    s_d.soft_rst_n = 1'b1;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    // Bus answer: one registered ack per request, dropped the cycle after
    s_d.ack   = req & ~s_q.ack;
    if (req && !s_q.ack) begin
      if (!serial_on) begin
        s_d.rdata = pursq_pkg::RESET_READ_VALUE;
      end else begin
        case (WB_ADR_I)
          pursq_pkg::CTRL_ADDR: begin
            s_d.rdata = {31'h0000_0000, s_q.gate_cfg};
          end
          pursq_pkg::STATUS_ADDR: begin
            s_d.rdata = status;
          end
          pursq_pkg::PATTERN_ADDR: begin
            s_d.rdata = pursq_pkg::CONTROL_PATTERN;
          end
          pursq_pkg::MC_EN1_ADDR: begin
            s_d.rdata = {31'h0000_0000, s_q.mc_en[0]};
          end
          pursq_pkg::MC_EN2_ADDR: begin
            s_d.rdata = {31'h0000_0000, s_q.mc_en[1]};
          end
          default: begin
            s_d.rdata = pursq_pkg::UNMAPPED_VALUE;
          end
        endcase
      end
    end

    // Writes land at the edge where the master sees ack
    if (wr_now) begin
      case (WB_ADR_I)
        pursq_pkg::CTRL_ADDR: begin
          s_d.gate_cfg   = WB_DAT_I[pursq_pkg::CTRL_GATE_EN_BIT];
          // Self-clearing pulse: a held soft reset would lock the port shut
          s_d.soft_rst_n = ~WB_DAT_I[pursq_pkg::CTRL_SOFT_RST_BIT];
        end
        pursq_pkg::MC_EN1_ADDR: begin
          s_d.mc_en[0] = WB_DAT_I[pursq_pkg::MC_EN_BIT];
        end
        pursq_pkg::MC_EN2_ADDR: begin
          s_d.mc_en[1] = WB_DAT_I[pursq_pkg::MC_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    s_d.gate_en  = s_q.gate_cfg & CHARGE_PUMP_OK & s_q.cp_en;
    s_d.boost_en = |s_q.mc_en;
    s_d.act      = '0;
    for (int i = 0; i < NTRIG; i++) begin
      // Even triggers serve channel one, odd ones channel two
      s_d.act[i] = ACTUATION_TRIGGER_INPUTS[i] & s_q.mc_en[i % 2] & core_rst_n;
    end

    // ----------------------------------------------------------------
    // Phase tracker
    // ----------------------------------------------------------------
    // Status only; no enable depends on it, so a stale phase is harmless
    case (s_q.phase)
      pursq_pkg::PH_SUPPLY: begin
        if (s_q.sgr_n) begin
          s_d.phase = pursq_pkg::PH_CHARGE_PUMP;
        end
      end
      pursq_pkg::PH_CHARGE_PUMP: begin
        if (s_q.cp_en) begin
          s_d.phase = pursq_pkg::PH_PLL;
        end
      end
      pursq_pkg::PH_PLL: begin
        if (s_q.pll_en && PLL_LOCKED) begin
          s_d.phase = pursq_pkg::PH_HOST_RESET;
        end
      end
      pursq_pkg::PH_HOST_RESET: begin
        if (HOST_RESET_PIN_N) begin
          s_d.phase = pursq_pkg::PH_IO_READY;
        end
      end
      pursq_pkg::PH_IO_READY: begin
        if (serial_on) begin
          s_d.phase = pursq_pkg::PH_CONFIG;
        end
      end
      pursq_pkg::PH_CONFIG: begin
        if (|s_q.mc_en) begin
          s_d.phase = pursq_pkg::PH_RUN;
        end
      end
      pursq_pkg::PH_RUN: begin
        s_d.phase = pursq_pkg::PH_RUN;
      end
      default: begin
        s_d.phase = pursq_pkg::PH_SUPPLY;
      end
    endcase

    // ----------------------------------------------------------------
    // Core reset
    // ----------------------------------------------------------------
    // Core reset clears configuration and run state; ack and soft pulse go on
    if (!core_rst_n) begin
      s_d.gate_cfg = 1'b0;
      s_d.gate_en  = 1'b0;
      s_d.mc_en    = 2'b00;
      s_d.boost_en = 1'b0;
      s_d.act      = '0;
      if (s_q.phase > pursq_pkg::PH_HOST_RESET) begin
        s_d.phase = pursq_pkg::PH_HOST_RESET;
      end
    end
    if (!s_q.sgr_n) begin
      s_d.phase = pursq_pkg::PH_SUPPLY;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s_q            <= '0;
      s_q.soft_rst_n <= 1'b1;
      s_q.phase      <= pursq_pkg::PH_SUPPLY;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign WB_DAT_O                 = s_q.rdata;
  assign WB_ACK_O                 = s_q.ack;
  assign SUPPLY_GOOD_RESET        = ~s_q.sgr_n;
  assign CORE_RESET_COMBINED_N    = core_rst_n;
  assign CHARGE_PUMP_EN           = s_q.cp_en;
  assign PLL_EN                   = s_q.pll_en;
  assign SERIAL_READY             = serial_on;
  assign GATE_SUPPLY_REGULATOR_EN = s_q.gate_en;
  assign MICROCORE_EN             = s_q.mc_en;
  assign BOOST_EN                 = s_q.boost_en;
  assign ACTUATE                  = s_q.act;
endmodule

// ### tb/pursq_chk.sv
// Port checker for the power-up sequencer.
// Assumes it is bound onto every pursq_sequencer instance.
`timescale 1ns/1ps
module pursq_chk #(
  parameter int unsigned NTRIG        = 4,
  parameter int unsigned IO_READY_CYC = pursq_pkg::IO_READY_CYC
) (
  input wire logic             REF_CLK,
  input wire logic             SRST,
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic [31:0]      WB_DAT_O,
  input wire logic             WB_ACK_O,
  input wire logic             CORE_LOGIC_SUPPLY_OK,
  input wire logic             BOOST_RAIL_OK,
  input wire logic             CHARGE_PUMP_OK,
  input wire logic             REF_CLK_IN,
  input wire logic             HOST_RESET_PIN_N,
  input wire logic [NTRIG-1:0] ACTUATION_TRIGGER_INPUTS,
  input wire logic             SUPPLY_GOOD_RESET,
  input wire logic             CORE_RESET_COMBINED_N,
  input wire logic             CHARGE_PUMP_EN,
  input wire logic             PLL_EN,
  input wire logic             SERIAL_READY,
  input wire logic             GATE_SUPPLY_REGULATOR_EN,
  input wire logic [1:0]       MICROCORE_EN,
  input wire logic             BOOST_EN,
  input wire logic [NTRIG-1:0] ACTUATE
);
  logic             ref_q;
  logic [8:0]       idle_q;
  logic [NTRIG-1:0] mask;
  int unsigned      rel_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  for (genvar i = 0; i < NTRIG; i++) begin : g_mask
    assign mask[i] = MICROCORE_EN[i % 2];
  end
  // Cycles since the reference last moved, saturating
  always_ff @(posedge REF_CLK) begin
    ref_q <= REF_CLK_IN;
    if (SRST || REF_CLK_IN != ref_q)
      idle_q <= 9'h000;
    else if (idle_q != 9'h1FF)
      idle_q <= idle_q + 9'h001;
  end
  supply_release_a: assert property ($fell(SUPPLY_GOOD_RESET) |-> $past(CORE_LOGIC_SUPPLY_OK))
    else $error("supply-good reset released without supply");
  supply_loss_a: assert property (!CORE_LOGIC_SUPPLY_OK [*2] |-> ##[0:8] SUPPLY_GOOD_RESET)
    else $error("supply-good reset not asserted on supply loss");
  pump_start_a: assert property ($rose(CHARGE_PUMP_EN) |->
    $past(!SUPPLY_GOOD_RESET && BOOST_RAIL_OK)) else $error("charge pump started early");
  pll_ref_a: assert property (idle_q > 9'h0CD |-> !PLL_EN)
    else $error("PLL enabled without a running reference");
  // Cycles since the supply-good reset was released, saturating
  always_ff @(posedge REF_CLK) begin
    if (SRST || SUPPLY_GOOD_RESET)
      rel_q <= 0;
    else if (rel_q < IO_READY_CYC)
      rel_q <= rel_q + 1;
  end
  serial_gate_a: assert property (SERIAL_READY |->
    CORE_RESET_COMBINED_N && HOST_RESET_PIN_N && rel_q >= IO_READY_CYC)
    else $error("serial port open before its conditions hold");
  reset_and_a: assert property (!HOST_RESET_PIN_N || SUPPLY_GOOD_RESET |->
    !CORE_RESET_COMBINED_N) else $error("core reset not formed from its sources");
  closed_read_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !SERIAL_READY |=>
    WB_ACK_O && WB_DAT_O == 32'h0000_0000) else $error("closed port returned data");
  gate_pump_a: assert property ($rose(GATE_SUPPLY_REGULATOR_EN) |->
    $past(CHARGE_PUMP_OK && CHARGE_PUMP_EN)) else $error("gate regulator before pump");
  boost_after_a: assert property (BOOST_EN |-> $past(|MICROCORE_EN))
    else $error("boost control without microcore");
  actuate_map_a: assert property (CORE_RESET_COMBINED_N && $past(CORE_RESET_COMBINED_N) |->
    ACTUATE == $past(ACTUATION_TRIGGER_INPUTS & mask)) else $error("actuation mismatch");
  reset_ignore_a: assert property (!CORE_RESET_COMBINED_N |=>
    MICROCORE_EN == 2'h0 && ACTUATE == '0) else $error("enable kept in core reset");
  cover property (SERIAL_READY && MICROCORE_EN == 2'h3);
  cover property ($rose(GATE_SUPPLY_REGULATOR_EN));
  cover property ($fell(SERIAL_READY));
endmodule

bind pursq_sequencer pursq_chk #(.NTRIG(NTRIG), .IO_READY_CYC(IO_READY_CYC)) pursq_chk_inst (
  .REF_CLK(REF_CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CORE_LOGIC_SUPPLY_OK(CORE_LOGIC_SUPPLY_OK),
  .BOOST_RAIL_OK(BOOST_RAIL_OK), .CHARGE_PUMP_OK(CHARGE_PUMP_OK), .REF_CLK_IN(REF_CLK_IN),
  .HOST_RESET_PIN_N(HOST_RESET_PIN_N), .ACTUATION_TRIGGER_INPUTS(ACTUATION_TRIGGER_INPUTS),
  .SUPPLY_GOOD_RESET(SUPPLY_GOOD_RESET), .CORE_RESET_COMBINED_N(CORE_RESET_COMBINED_N),
  .CHARGE_PUMP_EN(CHARGE_PUMP_EN), .PLL_EN(PLL_EN), .SERIAL_READY(SERIAL_READY),
  .GATE_SUPPLY_REGULATOR_EN(GATE_SUPPLY_REGULATOR_EN), .MICROCORE_EN(MICROCORE_EN),
  .BOOST_EN(BOOST_EN), .ACTUATE(ACTUATE));

// ### tb/pursq_host.sv
// Host model: makes the 1 MHz reference and drives the reset pin.
// Assumes a 100 MHz clock and a lock flag from the bench.
`timescale 1ns/1ps
module pursq_host (
  input  wire logic clk,
  input  wire logic ref_on,
  input  wire logic pll_locked,
  input  wire logic pwr_down,
  output logic      ref_out,
  output logic      rst_pin_n
);
  logic [6:0] cnt_q = 7'h00;
  initial ref_out = 1'b0;
  initial rst_pin_n = 1'b0;
  // 50 cycles high, 50 low; stands low while the host has it off
  always @(posedge clk) begin
    cnt_q <= (cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
    ref_out <= ref_on && (cnt_q < 7'h32);
  end
  // Pin rises only after lock, and drops first on power-down
  always @(posedge clk) begin
    if (pwr_down)
      rst_pin_n <= 1'b0;
    else if (pll_locked)
      rst_pin_n <= 1'b1;
  end
endmodule

// ### tb/tb.sv
// Self-checking bench for the power-up sequencer.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'hF, trig = 4'h0, act;
  logic [31:0] dat = 32'h0, dat_o, exp_q[$];
  logic sup_ok = 1'b0, boost_ok = 1'b0, cp_ok = 1'b0, ref_on = 1'b0, locked = 1'b0;
  logic pwr_down = 1'b0, ref_in, pin_n, ack, sgr, crn, cp_en, pll_en, ready, gate_en;
  logic boost_en;
  logic [1:0]  mc_en;
  int mismatches = 0, tests_run = 0;
  always #5 clk = ~clk;
  // PLL stand-in: locks one cycle after it is started
  always @(posedge clk) locked <= pll_en;
  pursq_sequencer #(.NTRIG(4), .IO_READY_CYC(20)) pursq_sequencer_inst (
    .REF_CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .CORE_LOGIC_SUPPLY_OK(sup_ok), .BOOST_RAIL_OK(boost_ok), .CHARGE_PUMP_OK(cp_ok),
    .REF_CLK_IN(ref_in), .PLL_LOCKED(locked), .HOST_RESET_PIN_N(pin_n),
    .ACTUATION_TRIGGER_INPUTS(trig), .SUPPLY_GOOD_RESET(sgr), .CORE_RESET_COMBINED_N(crn),
    .CHARGE_PUMP_EN(cp_en), .PLL_EN(pll_en), .SERIAL_READY(ready),
    .GATE_SUPPLY_REGULATOR_EN(gate_en), .MICROCORE_EN(mc_en), .BOOST_EN(boost_en),
    .ACTUATE(act));
  pursq_host pursq_host_inst (.clk(clk), .ref_on(ref_on), .pll_locked(locked),
    .pwr_down(pwr_down), .ref_out(ref_in), .rst_pin_n(pin_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Classic cycle; request held until ack, then released for one cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // No answer time assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim)
      mismatches++;
  endtask
  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read data is compared against the oldest note when the ack arrives
  always @(posedge clk)
    if (ack === 1'b1 && !we && exp_q.size() > 0) check(dat_o, exp_q.pop_front());
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(43545));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(32'(sgr), 32'h1);
    check(32'(crn), 32'h0);
    check(32'(gate_en), 32'h0);
    rd(12'h008, 32'h0);
    bus(1'b1, 12'h100, 32'h1);
    check(32'(mc_en), 32'h0);
    $display("test closed_port done");
    sup_ok <= 1'b1;
    boost_ok <= 1'b1;
    ref_on <= 1'b1;
    wait_hi(cp_en, 50);
    check(32'(pll_en), 32'h0);
    wait_hi(ready, 3000);
    check(32'(pll_en), 32'h1);
    check(32'(crn), 32'h1);
    rd(12'h008, 32'h0000_00A8);
    rd(12'h0FC, 32'h0);
    // Supply good, PLL on and locked, io ready, phase five (configuration)
    rd(12'h004, 32'h0000_501D);
    $display("test power_up done");
    // Gate regulator enabled while the pump is still reported down
    bus(1'b1, 12'h000, 32'h1);
    rd(12'h000, 32'h1);
    repeat (3) @(posedge clk);
    check(32'(gate_en), 32'h0);
    cp_ok <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(gate_en), 32'h1);
    $display("test gate_supply done");
    bus(1'b1, 12'h100, 32'h1);
    bus(1'b1, 12'h120, 32'h1);
    rd(12'h120, 32'h1);
    check(32'(mc_en), 32'h3);
    check(32'(boost_en), 32'h1);
    for (int i = 0; i < 16; i++) begin
      trig <= 4'($urandom);
      repeat (2) @(posedge clk);
      check(32'(act), 32'(trig));
    end
    $display("test actuation done");
    trig <= 4'hF;
    bus(1'b1, 12'h000, 32'h2);
    repeat (3) @(posedge clk);
    check(32'(mc_en), 32'h0);
    check(32'(act), 32'h0);
    check(32'(boost_en), 32'h0);
    check(32'(gate_en), 32'h0);
    // Channel one alone: only the even triggers may act
    bus(1'b1, 12'h100, 32'h1);
    for (int i = 0; i < 8; i++) begin
      trig <= 4'($urandom);
      repeat (2) @(posedge clk);
      check(32'(act), 32'(trig & 4'h5));
    end
    $display("test soft_reset done");
    pwr_down <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(ready), 32'h0);
    check(32'(crn), 32'h0);
    rd(12'h008, 32'h0);
    // Supplies go only after the pin is low
    sup_ok <= 1'b0;
    ref_on <= 1'b0;
    repeat (300) @(posedge clk);
    check(32'(sgr), 32'h1);
    check(32'(cp_en), 32'h0);
    check(32'(pll_en), 32'h0);
    $display("test power_down done");
    results();
  end
endmodule
